// ### rtl/scc_config_reg.sv
// Short-circuit and two-level turn-off configuration register
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Register decoded at frame address 0x03
// [RQ2] Frame: rw bit23, data 17:8, crc 7:0
// [RQ3] Writes blocked outside configuration mode
// [RQ4] Turn-off voltage code bits 9:6, default 3
// [RQ5] Threshold code bits 5:3, default 2
// [RQ6] Slow filter: 400 ns plus 100 ns per code
// [RQ7] Fast filter: 100 ns plus 100 ns per code
// [RQ8] Fast-filter change loads filter code 4
// [RQ9] Fast-filter bit selects shorter table
// [RQ10] Threshold and filter codes only three bits
// [RQ11] Leaving configuration mode stores config CRC
// [RQ12] Device reset bit restores defaults
// [RQ13] Locked write leaves fields unchanged
module scc_config_reg #(
   parameter int FRAME_W   = scc_pkg::FRAME_W,
   parameter int DATA_W    = scc_pkg::DATA_W,
   parameter int CRC_W     = scc_pkg::CRC_W,
   parameter int FILT_NS_W = scc_pkg::FILT_NS_W
) (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire logic                      frame_valid,
   input  wire logic [FRAME_W-1:0]        frame,
   input  wire logic                      config_enable,
   input  wire logic                      device_reset,
   input  wire logic                      fast_filter_select,
   input  wire logic                      config_exit,
   input  wire logic [CRC_W-1:0]          config_crc_in,
   output      logic [DATA_W-1:0]         read_data,
   output      logic                      read_hit,
   output      logic [3:0]                two_level_turnoff_voltage_code,
   output      logic [2:0]                short_circuit_threshold_code,
   output      logic [2:0]                short_circuit_filter_code,
   output      logic [FILT_NS_W-1:0]      filter_time_ns,
   output      logic [CRC_W-1:0]          stored_crc
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      scc_pkg::scc_fields_type             fields;
      logic                                ff_prev;
      logic [FILT_NS_W-1:0]                filt_ns;
      logic [CRC_W-1:0]                    crc;
      logic [DATA_W-1:0]                   rdata;
      logic                                rhit;
   } scc_state_type;

   scc_state_type state_q;
   scc_state_type state_d;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Field values after reset or a device reset request
   function automatic scc_pkg::scc_fields_type defaults();
      scc_pkg::scc_fields_type f;
      f.two_level_turnoff_voltage_code = scc_pkg::TLTO_DEFAULT;
      f.short_circuit_threshold_code   = scc_pkg::THR_DEFAULT;
      f.short_circuit_filter_code      = scc_pkg::FILT_DEFAULT;
      return f;
   endfunction

   // Split the ten data bits of a frame into the three fields
   function automatic scc_pkg::scc_fields_type unpack_fields(
      input logic [DATA_W-1:0] data
   );
      scc_pkg::scc_fields_type f;
      f.two_level_turnoff_voltage_code =
         data[scc_pkg::TLTO_HI:scc_pkg::TLTO_LO];                 // RQ4
      f.short_circuit_threshold_code   =
         data[scc_pkg::THR_HI:scc_pkg::THR_LO];                   // RQ5
      f.short_circuit_filter_code      =
         data[scc_pkg::FILT_HI:scc_pkg::FILT_LO];                 // RQ10
      return f;
   endfunction

   // Address match of a valid frame
   function automatic logic addr_hit(
      input logic                   valid,
      input scc_pkg::scc_frame_type fr
   );
      logic match;
      match = (fr.addr == scc_pkg::SHORT_CIRCUIT_TURNOFF_CONFIG_ADDR);
      return valid && match;                                       // RQ1
   endfunction

   // Table lookup in ns; code is three bits so no undefined entry
   function automatic logic [FILT_NS_W-1:0] filt_time(
      input logic [2:0] code,
      input logic       fast
   );
      int base;
      base = fast ? scc_pkg::FILT_FAST_BASE_NS                  // RQ9
                  : scc_pkg::FILT_SLOW_BASE_NS;
      return FILT_NS_W'(base +
             int'(code) * scc_pkg::FILT_STEP_NS);                // RQ6
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic                   hit;
      logic                   is_read;
      logic                   is_write;
      logic                   ff_changed;
      scc_pkg::scc_frame_type fr;
      scc_pkg::scc_fields_type wr_fields;
      hit        = 1'b0;
      is_read    = 1'b0;
      is_write   = 1'b0;
      ff_changed = 1'b0;
      fr         = scc_pkg::scc_frame_type'(frame);              // RQ2
      wr_fields  = unpack_fields(fr.data);
      state_d    = state_q;

      hit        = addr_hit(frame_valid, fr);                     // RQ1
      is_read    = hit && !fr.read_write_select;
      // Write only in configuration mode; otherwise dropped
      is_write   = hit && fr.read_write_select && config_enable;  // RQ3 RQ13
      ff_changed = (fast_filter_select != state_q.ff_prev);

      state_d.ff_prev = fast_filter_select;
      state_d.rhit    = 1'b0;

      // Reads are answered in any mode, one cycle later
      if (is_read) begin
         state_d.rdata = state_q.fields;
         state_d.rhit  = 1'b1;
      end

      if (is_write) begin
         state_d.fields = wr_fields;                              // RQ4 RQ5
      end

      // Table change wins over a same-cycle write of the filter code
      if (ff_changed) begin
         state_d.fields.short_circuit_filter_code =
            scc_pkg::FILT_ON_FF_CHANGE;                           // RQ8
      end

      // CRC of the configured registers comes from outside
      if (config_exit) begin
         state_d.crc = config_crc_in;                             // RQ11
      end

      // Device reset beats every other source of field change
      if (device_reset) begin
         state_d.fields = defaults();                             // RQ12
      end

      // Time follows the next fields, so both move in one cycle
      state_d.filt_ns = filt_time(state_d.fields.short_circuit_filter_code,
                                  fast_filter_select);            // RQ7
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q.fields  <= defaults();
         state_q.ff_prev <= 1'b0;
         state_q.filt_ns <= filt_time(scc_pkg::FILT_DEFAULT, 1'b0);
         state_q.crc     <= '0;
         state_q.rdata   <= '0;
         state_q.rhit    <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign read_data                      = state_q.rdata;
   assign read_hit                       = state_q.rhit;
   assign two_level_turnoff_voltage_code =
      state_q.fields.two_level_turnoff_voltage_code;
   assign short_circuit_threshold_code   =
      state_q.fields.short_circuit_threshold_code;
   assign short_circuit_filter_code      =
      state_q.fields.short_circuit_filter_code;
   assign filter_time_ns                 = state_q.filt_ns;
   assign stored_crc                     = state_q.crc;

endmodule

// ### rtl/scc_pkg.sv
// Package: frame layout, register address, field layout and defaults
package scc_pkg;

   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_W      = 24;
   localparam int RW_BIT       = 23;
   localparam int ADDR_HI      = 22;
   localparam int ADDR_LO      = 18;
   localparam int DATA_HI      = 17;
   localparam int DATA_LO      = 8;
   localparam int CRC_HI       = 7;
   localparam int CRC_LO       = 0;
   localparam int ADDR_W       = 5;
   localparam int DATA_W       = 10;
   localparam int CRC_W        = 8;

   localparam logic [ADDR_W-1:0] SHORT_CIRCUIT_TURNOFF_CONFIG_ADDR =
      5'h03;

   // ----------------------------------------------------------------
   // Field layout inside the ten data bits
   // ----------------------------------------------------------------
   localparam int TLTO_HI      = 9;
   localparam int TLTO_LO      = 6;
   localparam int THR_HI       = 5;
   localparam int THR_LO       = 3;
   localparam int FILT_HI      = 2;
   localparam int FILT_LO      = 0;

   localparam logic [3:0] TLTO_DEFAULT      = 4'h3;
   localparam logic [2:0] THR_DEFAULT       = 3'h2;
   localparam logic [2:0] FILT_DEFAULT      = 3'h4;
   localparam logic [2:0] FILT_ON_FF_CHANGE = 3'h4;

   // ----------------------------------------------------------------
   // Filter time tables, ns
   // ----------------------------------------------------------------
   localparam int FILT_SLOW_BASE_NS = 400;
   localparam int FILT_FAST_BASE_NS = 100;
   localparam int FILT_STEP_NS      = 100;
   localparam int FILT_NS_W         = 11;

   // Data pattern carried by a frame
   typedef struct packed {
      logic [3:0] two_level_turnoff_voltage_code;
      logic [2:0] short_circuit_threshold_code;
      logic [2:0] short_circuit_filter_code;
   } scc_fields_type;

   // Frame as decoded by the serial engine
   typedef struct packed {
      logic                read_write_select;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
      logic [CRC_W-1:0]    crc;
   } scc_frame_type;

endpackage

// ### tb/scc_config_reg_assertions.sv
// Port checker for the configuration register
`timescale 1ns/1ps
module scc_config_reg_assertions (
   input wire logic        clk, reset, frame_valid, config_enable,
   input wire logic        device_reset, fast_filter_select, config_exit,
   input wire logic        read_hit,
   input wire logic [23:0] frame,
   input wire logic [7:0]  config_crc_in, stored_crc,
   input wire logic [9:0]  read_data,
   input wire logic [3:0]  two_level_turnoff_voltage_code,
   input wire logic [2:0]  short_circuit_threshold_code,
   input wire logic [2:0]  short_circuit_filter_code,
   input wire logic [10:0] filter_time_ns
);
   wire [9:0] f = {two_level_turnoff_voltage_code,
      short_circuit_threshold_code, short_circuit_filter_code};
   wire hit = frame_valid && frame[22:18] == 5'h03;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_rd; hit && !frame[23]; endsequence
   sequence s_wr; hit && frame[23] && !device_reset; endsequence
   property p_rd; s_rd |=> read_hit && read_data == $past(f); endproperty
   a_rd: assert property (p_rd) else $error("bad read answer");
   property p_idle; !(hit && !frame[23]) |=> !read_hit; endproperty
   a_idle: assert property (p_idle) else $error("stray read hit");
   property p_wr; s_wr and config_enable && $stable(fast_filter_select)
      |=> f == $past(frame[17:8]); endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_lock; s_wr and !config_enable && $stable(fast_filter_select)
      |=> $stable(f); endproperty
   a_lock: assert property (p_lock) else $error("locked write");
   property p_drst; device_reset |=> f == 10'h0D4; endproperty
   a_drst: assert property (p_drst) else $error("no defaults");
   property p_ff; !device_reset && $changed(fast_filter_select)
      |=> short_circuit_filter_code == 3'h4; endproperty
   a_ff: assert property (p_ff) else $error("no filter default");
   property p_time; filter_time_ns == ($past(fast_filter_select) ?
      11'd100 : 11'd400) + 11'd100 * short_circuit_filter_code; endproperty
   a_time: assert property (p_time) else $error("bad time");
   property p_crc; config_exit |=> stored_crc == $past(config_crc_in);
   endproperty
   a_crc: assert property (p_crc) else $error("crc not stored");
endmodule

// ### tb/scc_config_reg_tb.sv
// Bench for the configuration register
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
$display("unexpected %0t %h %h", $time, a, b); end end
module scc_config_reg_tb;
   logic clk = 1'b0, reset = 1'b1, cfg = 1'b0, drst = 1'b0, fast = 1'b0;
   logic cexit = 1'b0, fv, rhit;
   logic [7:0] crc_in = 8'h00, crc;
   logic [23:0] frame;
   logic [9:0] rdata;
   logic [3:0] tl;
   logic [2:0] th, fl;
   logic [10:0] ft;
   int n_mismatch = 0, total_checks = 0;
   logic [20:0] rows [3] = '{{10'h3FF, 11'd1100}, {10'h000, 11'd400},
                             {10'h2A9, 11'd500}};
   scc_host_model host_u (.clk(clk), .frame_valid(fv), .frame(frame));
   scc_config_reg dut_u (.clk(clk), .reset(reset), .frame_valid(fv),
      .frame(frame), .config_enable(cfg), .device_reset(drst),
      .fast_filter_select(fast), .config_exit(cexit), .config_crc_in(crc_in),
      .read_data(rdata), .read_hit(rhit), .two_level_turnoff_voltage_code(tl),
      .short_circuit_threshold_code(th), .short_circuit_filter_code(fl),
      .filter_time_ns(ft), .stored_crc(crc));
   task automatic rd(input logic [9:0] e);
      host_u.send(1'b0, 5'h03, 10'h000);
      `CHK(rhit, 1'b1)
      `CHK(rdata, e)
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial forever #2 clk = ~clk;
   initial begin
      #20000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (4) @(negedge clk);
      reset = 1'b0;
      `CHK({tl, th, fl}, 10'h0D4)
      `CHK(ft, 11'd800)
      cfg = 1'b1;
      foreach (rows[i]) begin
         host_u.send(1'b1, 5'h03, rows[i][20:11]);
         `CHK({tl, th, fl}, rows[i][20:11])
         `CHK(ft, rows[i][10:0])
         rd(rows[i][20:11]);
      end
      $display("test rows done");
      fast = 1'b1;
      @(negedge clk);
      `CHK(fl, 3'h4)
      `CHK(ft, 11'd500)
      host_u.send(1'b1, 5'h03, 10'h007);
      `CHK(ft, 11'd800)
      fast = 1'b0;
      @(negedge clk);
      `CHK(ft, 11'd800)
      host_u.send(1'b1, 5'h02, 10'h3FF);
      cfg = 1'b0;
      host_u.send(1'b1, 5'h03, 10'h155);
      rd(10'h004);
      host_u.send(1'b0, 5'h04, 10'h000);
      `CHK(rhit, 1'b0)
      $display("test lock done");
      drst = 1'b1;
      crc_in = 8'h5A;
      cexit = 1'b1;
      @(negedge clk);
      drst = 1'b0;
      cexit = 1'b0;
      crc_in = 8'hA5;
      @(negedge clk);
      `CHK({tl, th, fl}, 10'h0D4)
      `CHK(crc, 8'h5A)
      $display("test reset done");
      finish_test();
   end
endmodule
bind scc_config_reg scc_config_reg_assertions chk_u (.*);

// ### tb/scc_host_model.sv
// Host-side frame source
`timescale 1ns/1ps
module scc_host_model (
   input  wire logic        clk,
   output      logic        frame_valid,
   output      logic [23:0] frame
);
   initial begin
      frame_valid = 1'b0;
      frame = 24'h00_0000;
   end
   task automatic send(input logic rw, input logic [4:0] a,
                       input logic [9:0] d);
      @(negedge clk);
      frame_valid = 1'b1;
      frame = {rw, a, d, 8'h00};
      @(negedge clk);
      frame_valid = 1'b0;
      // Released frame never repeats its last value
      frame = ~frame;
   endtask
endmodule
